// *** core/deint_counter.sv ***
// Deintegrate counter with zero-crossing flip-flop and result push
`timescale 1ns/10ps
module deint_counter
(
  input  wire logic                                core_clk,    // Core clock
  input  wire logic                                arst_n,      // Async reset
  input  wire logic                                conv_en,     // Converter clock edge
  input  wire logic                                sample_en,   // End of high half
  input  wire logic                                deint_start, // Deintegrate begins
  input  wire logic                                comp_zero,   // Comparator crossed
  output logic                                     push_valid,  // Word offered
  input  wire logic                                push_ready,  // FIFO has room
  output logic [digit_scan_pkg::WORD_W-1:0]        push_data    // Digit and flag
);
  import digit_scan_pkg::*;

  cnt_state_e  state_reg;
  logic [19:0] count_reg;
  logic        zc_reg;
  logic        ovr_reg;
  logic [2:0]  push_idx_reg;
  logic        at_full;

  assign at_full    = (count_reg == FULL_SCALE_BCD);
  assign push_valid = (state_reg == CNT_PUSH);
  // MSD goes first; index 0 takes the top nibble
  assign push_data  = {ovr_reg,
                       count_reg[(COUNT_W - BCD_W) - 32'(push_idx_reg) * BCD_W +: BCD_W]};

  // late sampling
  // Taken at end of the high half so clock transients have settled
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zc_reg <= 1'b0;
    end
    else if (deint_start)
    begin
      zc_reg <= 1'b0;
    end
    else if (sample_en && state_reg != CNT_IDLE)
    begin
      zc_reg <= comp_zero;
    end
  end

  // Counter sequence
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg    <= CNT_IDLE;
      count_reg    <= '0;
      ovr_reg      <= 1'b0;
      push_idx_reg <= DIGIT_MSD;
    end
    else
    begin
      unique case (state_reg)
        CNT_IDLE:
        begin
          if (deint_start)
          begin
            state_reg <= CNT_SKIP;
            count_reg <= '0;
            ovr_reg   <= 1'b0;
          end
        end
        // first clock idle
        // Offsets the one-cycle-late zero detection
        CNT_SKIP:
        begin
          if (conv_en)
          begin
            state_reg <= CNT_COUNT;
          end
        end
        CNT_COUNT:
        begin
          if (zc_reg)
          begin
            state_reg    <= CNT_PUSH;
            push_idx_reg <= DIGIT_MSD;
          end
          else if (at_full)
          begin
            state_reg    <= CNT_PUSH;
            ovr_reg      <= 1'b1;
            push_idx_reg <= DIGIT_MSD;
          end
          else if (conv_en)
          begin
            count_reg <= bcd_inc(count_reg);
          end
        end
        // Stalls here while the FIFO is full
        CNT_PUSH:
        begin
          if (push_ready)
          begin
            if (push_idx_reg == DIGIT_LSD)
            begin
              state_reg <= CNT_IDLE;
            end
            push_idx_reg <= push_idx_reg + 3'h1;
          end
        end
      endcase
    end
  end

endmodule : deint_counter

// *** core/digit_scan_pkg.sv ***
// Shared constants for the dual-slope digit scanner
package digit_scan_pkg;

  // Converter clock is core_clk divided by two; each half is one core cycle
  localparam int unsigned CORE_CLK_HZ    = 100_000_000;
  localparam int unsigned CONV_CLK_HZ    = 50_000_000;
  localparam int unsigned CONV_DIV       = CORE_CLK_HZ / CONV_CLK_HZ;

  // Digit scan timing in converter clocks
  localparam logic [7:0]  SLOT_LEN       = 8'hC8;   // 200 counts per digit
  localparam logic [7:0]  SLOT_LAST      = 8'hC7;   // Final count of a slot
  localparam logic [7:0]  STROBE_AT      = 8'h64;   // 101st count, zero based

  // Digit layout
  localparam int unsigned DIGITS         = 5;
  localparam logic [2:0]  DIGIT_MSD      = 3'h0;
  localparam logic [2:0]  DIGIT_LSD      = 3'h4;
  localparam int unsigned BCD_W          = 4;
  localparam int unsigned COUNT_W        = DIGITS * BCD_W;

  // Result word in the FIFO: over-range flag above the four weighted bits
  localparam int unsigned WORD_W         = BCD_W + 1;
  localparam int unsigned WORD_OVR_BIT   = 4;
  localparam int unsigned FIFO_DEPTH     = 16;

  // Full scale reading; reaching it ends the count as an over-range
  localparam logic [19:0] FULL_SCALE_BCD = 20'h20000;

  // Reset values of the output pins
  localparam logic [4:0]  SEL_RST        = 5'h00;
  localparam logic [3:0]  BCD_RST        = 4'h0;

  // Deintegrate counter states
  typedef enum logic [1:0]
  {
    CNT_IDLE  = 2'b00,
    CNT_SKIP  = 2'b01,
    CNT_COUNT = 2'b10,
    CNT_PUSH  = 2'b11
  } cnt_state_e;

  // Decimal increment of a packed five digit reading
  function automatic logic [19:0] bcd_inc(input logic [19:0] value);
    logic [19:0] res;
    logic        carry;
    res   = value;
    carry = 1'b1;
    for (int i = 0; i < DIGITS; i++)
    begin
      if (carry)
      begin
        if (res[i*BCD_W +: BCD_W] == 4'h9)
        begin
          res[i*BCD_W +: BCD_W] = 4'h0;
        end
        else
        begin
          res[i*BCD_W +: BCD_W] = res[i*BCD_W +: BCD_W] + 4'h1;
          carry                 = 1'b0;
        end
      end
    end
    return res;
  endfunction : bcd_inc

  // One-hot select for a digit index, MSD at bit 4
  function automatic logic [4:0] digit_onehot(input logic [2:0] idx);
    logic [4:0] oh;
    oh = 5'h00;
    if (idx <= DIGIT_LSD)
    begin
      oh = 5'h10 >> idx;
    end
    return oh;
  endfunction : digit_onehot

endpackage : digit_scan_pkg

// *** core/dual_slope_digit_scan.sv ***
// Digit scanner of the dual-slope converter: count, buffer and multiplex out
`timescale 1ns/10ps
module dual_slope_digit_scan
(
  input  wire logic core_clk,             // 100 MHz core clock
  input  wire logic arst_n,               // Async reset, active low
  input  wire logic deint_start,          // One-cycle pulse, deintegrate begins
  input  wire logic comp_zero,            // Comparator zero-crossing level
  output logic      digit_select_msd,     // Most significant digit drive
  output logic      digit_select_fourth,  // Fourth digit drive
  output logic      digit_select_third,   // Middle digit drive
  output logic      digit_select_second,  // Second digit drive
  output logic      digit_select_lsd,     // Least significant digit drive
  output logic      bcd_weight_one,       // BCD bit, weight 1
  output logic      bcd_weight_two,       // BCD bit, weight 2
  output logic      bcd_weight_four,      // BCD bit, weight 4
  output logic      bcd_weight_eight,     // BCD bit, weight 8
  output logic      data_latch_n,         // Latch pulse, active low
  output logic      result_ready          // FIFO has room for a word, one cycle late
);
  import digit_scan_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Clock divider

  logic              phase_hi_reg;
  logic              conv_en;
  logic              sample_en;

  // Divide by two keeps the strobe at one core cycle; slower clocks need a wider divider
  // Converter clock high half is the cycle after conv_en
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_hi_reg <= 1'b0;
    end
    else
    begin
      phase_hi_reg <= ~phase_hi_reg;
    end
  end

  // Counting edge in phase 0, zero sampling closes phase 1
  assign conv_en   = ~phase_hi_reg;
  assign sample_en = phase_hi_reg;

  ////////////////////////////////////////////////////////////////////////
  // Counter and FIFO

  logic              push_valid;
  logic              push_ready;
  logic [WORD_W-1:0] push_data;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [WORD_W-1:0] fifo_data;

  // Counter pushes five words per result, MSD first
  deint_counter u_counter
  (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .conv_en     (conv_en),
    .sample_en   (sample_en),
    .deint_start (deint_start),
    .comp_zero   (comp_zero),
    .push_valid  (push_valid),
    .push_ready  (push_ready),
    .push_data   (push_data)
  );

  // Room for three whole results; the counter stalls when it fills
  result_fifo
  #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Scan timing

  logic [7:0]        slot_reg;
  logic [2:0]        idx_reg;
  logic [2:0]        idx_next;
  logic              advance;
  logic              pass_reg;
  logic              pass_start;
  logic              pass_end;
  logic              ovr_reg;
  logic              blank_reg;
  logic [BCD_W-1:0]  digit_mem [DIGITS];
  logic [4:0]        sel_reg;
  logic [3:0]        bcd_reg;
  logic              latch_n_reg;
  logic              ready_reg;
  logic              scan_wrap;
  logic [2:0]        show_idx;
  logic              blank_next;
  logic              sel_load;
  logic              latch_fire;

  // slot length
  // Slot closes after its 200th converter clock
  assign advance  = conv_en && (slot_reg == SLOT_LAST);
  // Wraps from the LSD straight back to the MSD
  // endless scan
  assign idx_next = (idx_reg == DIGIT_LSD) ? DIGIT_MSD : idx_reg + 3'h1;

  // Boundary into the MSD slot, where a whole scan begins
  assign scan_wrap  = advance && (idx_next == DIGIT_MSD);

  // A new result joins only at an MSD boundary, so a pass is never split
  // Held off while blanked, else its strobes would latch dark digits
  assign pass_start = scan_wrap && fifo_valid && !pass_reg && !blank_reg;
  assign pass_end   = advance && pass_reg && (idx_reg == DIGIT_LSD);
  // one word popped per slot of each latch pass, MSD first
  assign fifo_pop   = pass_start || (advance && pass_reg && !scan_wrap);

  // Slot counter runs on the converter clock
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slot_reg <= 8'h00;
    end
    else if (advance)
    begin
      slot_reg <= 8'h00;
    end
    else if (conv_en)
    begin
      slot_reg <= slot_reg + 8'h01;
    end
  end

  // Digit index starts on the LSD so the first boundary opens an MSD slot
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_reg <= DIGIT_LSD;
    end
    else if (advance)
    begin
      idx_reg <= idx_next;
    end
  end

  // Latch pass flag, one per result
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pass_reg <= 1'b0;
    end
    else if (pass_start)
    begin
      pass_reg <= 1'b1;
    end
    else if (pass_end)
    begin
      pass_reg <= 1'b0;
    end
  end

  // Over-range flag travels with each word of a result
  // Taken as the pass opens; every word of one result carries the same flag
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovr_reg <= 1'b0;
    end
    else if (pass_start)
    begin
      ovr_reg <= fifo_data[WORD_OVR_BIT];
    end
  end

  // over-range blank
  // Deintegrate start wins over a pass ending in the same cycle
  // Any deintegrate start clears it, even one the busy counter ignores
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blank_reg <= 1'b0;
    end
    else if (deint_start)
    begin
      blank_reg <= 1'b0;
    end
    else if (pass_end && ovr_reg)
    begin
      blank_reg <= 1'b1;
    end
  end

  // Digit store refreshed by each latch pass
  // No reset: digits read unknown until the first pass fills them
  always_ff @(posedge core_clk)
  begin
    if (fifo_pop)
    begin
      digit_mem[idx_next] <= fifo_data[BCD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pins

  // Slot shown after this edge; a boundary edge already moves to the next
  assign show_idx   = advance ? idx_next : idx_reg;
  // Dark after an over-range pass; deintegrate start overrides the blank
  assign blank_next = !deint_start && (blank_reg || (pass_end && ovr_reg));
  // scan resumes
  // Pins reload at every boundary and when a blank ends mid-slot
  assign sel_load   = (deint_start && blank_reg) || advance;

  // one-hot select
  // A single index feeds the decode, so two selects never meet
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_reg <= SEL_RST;
    end
    else if (sel_load)
    begin
      sel_reg <= blank_next ? SEL_RST : digit_onehot(show_idx);
    end
  end

  // bits with select
  // Same load term and index as the selects, so both move on one edge
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bcd_reg <= BCD_RST;
    end
    else if (sel_load)
    begin
      bcd_reg <= fifo_pop ? fifo_data[BCD_W-1:0] : digit_mem[show_idx];
    end
  end

  // mid-slot latch
  // Low for one core cycle, half a converter clock, at the 101st count
  assign latch_fire = pass_reg && sample_en && (slot_reg == STROBE_AT);
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_n_reg <= 1'b1;
    end
    else
    begin
      latch_n_reg <= ~latch_fire;
    end
  end

  // Back-pressure visible to the measurement sequencer
  // One cycle late, so a start right after the last free word may stall
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= push_ready;
    end
  end

  // Pins straight from their flip-flops, MSD select at bit 4
  assign digit_select_msd    = sel_reg[4];
  assign digit_select_fourth = sel_reg[3];
  assign digit_select_third  = sel_reg[2];
  assign digit_select_second = sel_reg[1];
  assign digit_select_lsd    = sel_reg[0];

  // Weighted bits of the shown digit
  assign bcd_weight_one      = bcd_reg[0];
  assign bcd_weight_two      = bcd_reg[1];
  assign bcd_weight_four     = bcd_reg[2];
  assign bcd_weight_eight    = bcd_reg[3];

  // Strobe and back-pressure
  assign data_latch_n        = latch_n_reg;
  assign result_ready        = ready_reg;

endmodule : dual_slope_digit_scan

// *** core/result_fifo.sv ***
// Parameterised FIFO holding result digits between counter and scanner
`timescale 1ns/10ps
module result_fifo
#(
  parameter int unsigned WIDTH = 5,
  parameter int unsigned DEPTH = 16
)
(
  input  wire logic             core_clk,   // Core clock
  input  wire logic             arst_n,     // Async reset, active low
  input  wire logic             in_valid,   // Writer offers a word
  output logic                  in_ready,   // Space available
  input  wire logic [WIDTH-1:0] in_data,    // Word written
  output logic                  out_valid,  // Word available
  input  wire logic             out_ready,  // Reader takes the word
  output logic      [WIDTH-1:0] out_data    // Head word
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) ||
                     (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage, no reset needed on data
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
    end
    else if (push)
    begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ptr_reg <= '0;
    end
    else if (pop)
    begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

endmodule : result_fifo

// *** testbench/digit_scan_asserts.sv ***
// Concurrent checks on the digit scanner pins
`timescale 1ns/10ps
module digit_scan_asserts
(
  input wire logic core_clk,             // Core clock
  input wire logic arst_n,               // Async reset
  input wire logic deint_start,          // Deintegrate begins
  input wire logic comp_zero,            // Comparator level
  input wire logic digit_select_msd,     // MSD select
  input wire logic digit_select_fourth,  // Fourth select
  input wire logic digit_select_third,   // Third select
  input wire logic digit_select_second,  // Second select
  input wire logic digit_select_lsd,     // LSD select
  input wire logic bcd_weight_one,       // Weight 1
  input wire logic bcd_weight_two,       // Weight 2
  input wire logic bcd_weight_four,      // Weight 4
  input wire logic bcd_weight_eight,     // Weight 8
  input wire logic data_latch_n,         // Latch, active low
  input wire logic result_ready          // FIFO room
);
  logic [4:0] sel;
  logic [3:0] bcd;
  logic [4:0] sel_q;
  logic [8:0] run;
  logic       from_nz;
  logic       seen;

  assign sel = {digit_select_msd, digit_select_fourth, digit_select_third,
                digit_select_second, digit_select_lsd};
  assign bcd = {bcd_weight_eight, bcd_weight_four, bcd_weight_two, bcd_weight_one};

  // Segment length; a resumed slot is partial, so from_nz marks full ones
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_q   <= 5'h00;
      run     <= 9'h000;
      from_nz <= 1'b0;
      seen    <= 1'b0;
    end
    else
    begin
      sel_q   <= sel;
      run     <= (sel != sel_q) ? 9'h000 : run + 9'h001;
      from_nz <= (sel != sel_q) ? (sel_q != 5'h00) : from_nz;
      seen    <= seen | (sel != 5'h00);
    end
  end

  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_sel_onehot: assert property ($onehot0(sel))
    else $error("several digit selects high");
  chk_slot_len: assert property ((sel != sel_q && sel_q != 5'h00 && sel != 5'h00 && from_nz)
    |-> run == 9'h18F)
    else $error("digit slot not 400 cycles");
  chk_scan_order: assert property ((sel != sel_q && sel_q != 5'h00 && sel != 5'h00)
    |-> sel == {sel_q[0], sel_q[4:1]})
    else $error("digit select out of order");
  chk_latch_width: assert property ($fell(data_latch_n) |=> $rose(data_latch_n))
    else $error("latch pulse not one cycle");
  chk_latch_mid: assert property ($fell(data_latch_n) |-> sel != 5'h00 && run == 9'h0C8)
    else $error("latch pulse off slot midpoint");
  chk_bcd_stable: assert property ((sel == sel_q && sel != 5'h00) |-> $stable(bcd))
    else $error("weighted bits moved within slot");
  chk_blank_hold: assert property ((seen && sel == 5'h00 && !deint_start
    && !$past(deint_start)) |=> sel == 5'h00)
    else $error("selects left blank without deintegrate");
  chk_blank_end: assert property ((seen && sel == 5'h00 && deint_start)
    |-> ##[1:2] sel != 5'h00)
    else $error("scan did not resume");
endmodule : digit_scan_asserts

bind dual_slope_digit_scan digit_scan_asserts digit_scan_asserts_i
(
  .core_clk(core_clk), .arst_n(arst_n), .deint_start(deint_start), .comp_zero(comp_zero),
  .digit_select_msd(digit_select_msd), .digit_select_fourth(digit_select_fourth),
  .digit_select_third(digit_select_third), .digit_select_second(digit_select_second),
  .digit_select_lsd(digit_select_lsd), .bcd_weight_one(bcd_weight_one),
  .bcd_weight_two(bcd_weight_two), .bcd_weight_four(bcd_weight_four),
  .bcd_weight_eight(bcd_weight_eight), .data_latch_n(data_latch_n),
  .result_ready(result_ready)
);

// *** testbench/display_latch_model.sv ***
// Receiving latch model: stores a digit on each latch pulse
`timescale 1ns/10ps
module display_latch_model
(
  input  wire logic        core_clk,      // Core clock
  input  wire logic [4:0]  sel,           // Digit selects, MSD at bit 4
  input  wire logic [3:0]  bcd,           // Weighted bits
  input  wire logic        data_latch_n,  // Latch strobe, active low
  output logic      [19:0] shown,         // Latched reading, MSD on top
  output int               pulses         // Latch pulses seen
);
  initial
  begin
    shown  = 20'h00000;
    pulses = 0;
  end

  // bits go to the selected digit, taken on the low level
  // comparator delay stays in the reading; a host may subtract it
  always @(posedge core_clk)
  begin
    if (data_latch_n === 1'b0)
    begin
      pulses <= pulses + 1;
      for (int i = 0; i < 5; i++)
      begin
        if (sel[i] === 1'b1)
        begin
          shown[i*4 +: 4] <= bcd;
        end
      end
    end
  end
endmodule : display_latch_model

// *** testbench/dual_slope_digit_scan_bench.sv ***
// Self-checking bench for the dual-slope digit scanner
`timescale 1ns/10ps
module dual_slope_digit_scan_bench;
  logic        core_clk;
  logic        arst_n;
  logic        deint_start;
  logic        comp_zero;
  wire  [4:0]  sel;
  wire  [3:0]  bcd;
  wire         data_latch_n;
  wire         result_ready;
  logic [19:0] shown;
  int          pulses;
  int          error_cnt;
  int          num_checks;
  int          cycles;
  int          p;
  logic        low_seen;

  dual_slope_digit_scan dual_slope_digit_scan_i
  (
    .core_clk(core_clk), .arst_n(arst_n), .deint_start(deint_start), .comp_zero(comp_zero),
    .digit_select_msd(sel[4]), .digit_select_fourth(sel[3]), .digit_select_third(sel[2]),
    .digit_select_second(sel[1]), .digit_select_lsd(sel[0]), .bcd_weight_one(bcd[0]),
    .bcd_weight_two(bcd[1]), .bcd_weight_four(bcd[2]), .bcd_weight_eight(bcd[3]),
    .data_latch_n(data_latch_n), .result_ready(result_ready)
  );

  display_latch_model display_latch_model_i
  (
    .core_clk(core_clk), .sel(sel), .bcd(bcd), .data_latch_n(data_latch_n),
    .shown(shown), .pulses(pulses)
  );

  //////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;

  // Hang guard and FIFO refusal monitor
  always @(posedge core_clk)
  begin
    cycles++;
    if (arst_n === 1'b1 && result_ready === 1'b0)
    begin
      low_seen = 1'b1;
    end
    if (cycles == 95000)
    begin
      error_cnt++;
      $display("mismatch at %0t: run too long", $time);
      end_sim();
    end
  end

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  // Reading of a five digit latched word
  function automatic int from_bcd(input logic [19:0] v);
    int r;
    r = 0;
    for (int i = 4; i >= 0; i--)
    begin
      r = r * 10 + int'(v[i*4 +: 4]);
    end
    return r;
  endfunction : from_bcd

  // Expected reading: crossing after n clocks, or full scale when it never comes
  function automatic logic close_to(input logic [19:0] v, input int n);
    int d;
    d = from_bcd(v) - n;
    if (n < 0)
    begin
      return v === 20'h20000;
    end
    return (^v !== 1'bx) && d == 0;
  endfunction : close_to

  // One conversion; comp_zero rises n converter clocks in, never when n < 0
  task automatic convert(input int n);
    int w;
    w = 0;
    while (result_ready !== 1'b1 && w < 8000)
    begin
      step(1);
      w++;
    end
    check(result_ready === 1'b1, "no room for a result");
    deint_start = 1'b1;
    comp_zero   = (n == 0);
    step(1);
    deint_start = 1'b0;
    if (n > 0)
    begin
      step(2 * n);
      comp_zero = 1'b1;
    end
    step(8);
    comp_zero = 1'b0;
  endtask : convert

  task automatic run_one(input int n);
    int w;
    w = 0;
    p = pulses;
    convert(n);
    while (pulses < p + 5 && w < 48000)
    begin
      step(1);
      w++;
    end
    check(pulses == p + 5, "latch pass missing");
    check(close_to(shown, n), "wrong reading");
  endtask : run_one

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk    = 1'b0;
    arst_n      = 1'b0;
    deint_start = 1'b0;
    comp_zero   = 1'b0;
    error_cnt   = 0;
    num_checks  = 0;
    cycles      = 0;
    low_seen    = 1'b0;
    p           = $urandom(32'h0B513ACA);
    repeat (8) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    // Crossing at once, random counts, carry through three digits
    run_one(0);
    repeat (2) run_one(1 + $urandom % 400);
    run_one(1000);
    p = pulses;
    step(2500);
    check(pulses == p, "extra latch pulses");
    check(sel !== 5'h00, "scan stopped");
    // Over-range then blanking until the next deintegrate
    run_one(-1);
    step(1000);
    check(sel === 5'h00, "selects not blanked");
    run_one(5);
    // Back to back results fill the FIFO, then it drains
    low_seen = 1'b0;
    repeat (4) convert(1);
    check(low_seen === 1'b1, "FIFO never refused");
    step(8000);
    check(result_ready === 1'b1, "FIFO did not drain");
    end_sim();
  end
endmodule : dual_slope_digit_scan_bench
